// ---- design/sac_pkg.sv ----
// Shared constants and types for the successive-approximation acquisition control
package sac_pkg;
    // Timing at the 100 ns system clock
    localparam int CLK_NS = 100;
    localparam int TRIAL_NS = 700;
    localparam int TRIAL_CYC = (TRIAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int ONESHOT_NS = 1500;
    localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRIAL_W = 4;
    localparam int SHOT_W = 5;
    localparam logic [TRIAL_W-1:0] TRIAL_LAST = TRIAL_W'(TRIAL_CYC - 1);
    localparam logic [SHOT_W-1:0] SHOT_LOAD = SHOT_W'(ONESHOT_CYC);
    localparam logic [SHOT_W-1:0] SHOT_ONE = 5'h01;
    localparam logic [TRIAL_W-1:0] TRIAL_ZERO = 4'h0;
    localparam logic [TRIAL_W-1:0] TRIAL_STEP = 4'h1;

    // Converter word
    localparam int N_BITS = 12;
    localparam int CONV_TRIALS = 12;
    localparam logic [3:0] DEC_LAST = 4'(CONV_TRIALS - 1);
    localparam logic [N_BITS-1:0] SAR_INIT = 12'h7FF;
    localparam logic [N_BITS-1:0] SAR_IDLE = 12'hFFF;
    localparam logic [N_BITS-1:0] PTR_MSB = 12'h800;
    localparam logic [N_BITS-1:0] PTR_LSB = 12'h001;
    localparam logic [N_BITS-1:0] WORD_ZERO = 12'h000;

    // Register map, byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;
    localparam int CTRL_START_BIT = 0;
    localparam int N_EV = 2;
    localparam int EV_DONE = 0;
    localparam int EV_START = 1;
    localparam logic [N_EV-1:0] EV_NONE = 2'h0;

    // Processor byte lanes of the result
    localparam logic IO_SEL_LO = 1'b0;
    localparam int HI_PAD = 4;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INIT = 3'b010,
        ST_CONV = 3'b100
    } sac_state_t;
endpackage : sac_pkg

// ---- design/sac_tick_gen.sv ----
// Trial period divider producing one tick per trial
`timescale 1ns/10ps
`default_nettype none
module sac_tick_gen
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic srst,
    output logic tick
);
    logic [TRIAL_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Free running period counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= TRIAL_ZERO;
        else if (srst || cnt_r == TRIAL_LAST)
            cnt_r <= TRIAL_ZERO;
        else
            cnt_r <= cnt_r + TRIAL_STEP;
    end

    // One cycle pulse at the end of each period
    assign tick = (cnt_r == TRIAL_LAST) && !srst;
endmodule : sac_tick_gen
`default_nettype wire

// ---- design/sac_top.sv ----
// Successive-approximation acquisition controller with processor port and registers
`timescale 1ns/10ps
`default_nettype none
module sac_top
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic io_sel,
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    output logic [7:0] io_data_o,
    output logic io_data_oe,
    output logic processor_ready_in,
    input wire logic comp_in,
    output logic [N_BITS-1:0] dac_bit_n,
    output logic conversion_complete,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    sac_state_t state_r;
    logic [N_BITS-1:0] sar_n_r;
    logic [N_BITS-1:0] sar_nxt;
    logic [N_BITS-1:0] ptr_r;
    logic [N_BITS-1:0] ptr_lo;
    logic [N_BITS-1:0] result_r;
    logic [SHOT_W-1:0] shot_r;
    logic start_n_r;
    logic cc_r;
    logic ready_r;
    logic [7:0] io_data_r;
    logic [31:0] rdata_r;
    logic [N_EV-1:0] status_r;
    logic [N_EV-1:0] mask_r;
    logic [N_EV-1:0] ev;
    logic tick;
    logic io_wr_hit;
    logic io_rd_hit;
    logic sw_start;
    logic fire;
    logic decide;
    logic done_pulse;
    logic [3:0] dec_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Processor port decode, shared by both strobes
    function automatic logic io_hit(input logic sel_n, input logic strobe_n);
        io_hit = !sel_n && !strobe_n;
    endfunction : io_hit

    assign io_wr_hit = io_hit(cs_n, io_write_strobe_n);
    assign io_rd_hit = io_hit(cs_n, io_read_strobe_n);
    assign sw_start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START_BIT];
    assign fire = (io_wr_hit || sw_start) && shot_r == SHOT_W'(0);

    ////////////////////////////////////////////////////////////////////////
    // Trial period source
    sac_tick_gen u_tick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .srst(srst),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Start one-shot, longer than one trial period
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            shot_r <= SHOT_W'(0);
        else if (srst)
            shot_r <= SHOT_W'(0);
        else if (fire)
            shot_r <= SHOT_LOAD;
        else if (shot_r != SHOT_W'(0))
            shot_r <= shot_r - SHOT_ONE;
    end

    // Active low start level and processor ready, both from the one-shot
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_n_r <= 1'b1;
            ready_r <= 1'b1;
        end
        else if (srst)
        begin
            start_n_r <= 1'b1;
            ready_r <= 1'b1;
        end
        else
        begin
            start_n_r <= !(fire || shot_r > SHOT_ONE);
            ready_r <= !(fire || shot_r > SHOT_ONE);
        end
    end

    assign processor_ready_in = ready_r;

    ////////////////////////////////////////////////////////////////////////
    // Per-bit trial update: decided bit from comparator, next bit tried
    assign ptr_lo = ptr_r >> 1;
    genvar gi;
    generate
        for (gi = 0; gi < N_BITS; gi++)
        begin : g_bit
            // Comparator high means input above the DAC: keep the bit on
            assign sar_nxt[gi] = ptr_r[gi] ? !comp_in :
                                 ptr_lo[gi] ? 1'b0 : sar_n_r[gi];
        end
    endgenerate

    // A decision happens on a tick once start has returned high
    assign decide = tick && start_n_r && state_r != ST_IDLE;
    assign done_pulse = decide && ptr_r == PTR_LSB;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: idle, start held, bit trials
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else if (srst)
            state_r <= ST_IDLE;
        else if (tick)
        begin
            case (state_r)
                ST_IDLE:
                    if (!start_n_r)
                        state_r <= ST_INIT;
                ST_INIT:
                    if (start_n_r)
                        state_r <= ST_CONV;
                ST_CONV:
                    if (!start_n_r)
                        state_r <= ST_INIT;
                    else if (ptr_r == PTR_LSB)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
        else if (state_r != ST_IDLE && state_r != ST_INIT && state_r != ST_CONV)
            state_r <= ST_IDLE;
    end

    // Approximation register and trial pointer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sar_n_r <= SAR_IDLE;
            ptr_r <= PTR_MSB;
        end
        else if (srst)
        begin
            sar_n_r <= SAR_IDLE;
            ptr_r <= PTR_MSB;
        end
        else if (tick && !start_n_r)
        begin
            sar_n_r <= SAR_INIT;
            ptr_r <= PTR_MSB;
        end
        else if (decide)
        begin
            sar_n_r <= sar_nxt;
            ptr_r <= (ptr_r == PTR_LSB) ? PTR_MSB : ptr_lo;
        end
    end

    assign dac_bit_n = sar_n_r;

    // Conversion complete: set at start, low during trials, set after LSB
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cc_r <= 1'b0;
        else if (srst)
            cc_r <= 1'b0;
        else if (tick && !start_n_r)
            cc_r <= 1'b1;
        else if (done_pulse)
            cc_r <= 1'b1;
        else if (decide)
            cc_r <= 1'b0;
    end

    assign conversion_complete = cc_r;

    // Result captured active high when the LSB is decided
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            result_r <= WORD_ZERO;
        else if (srst)
            result_r <= WORD_ZERO;
        else if (done_pulse)
            result_r <= ~sar_nxt;
    end

    // Decision counter, watched by the checks only
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dec_cnt_r <= 4'h0;
        else if (srst || (tick && !start_n_r))
            dec_cnt_r <= 4'h0;
        else if (decide)
            dec_cnt_r <= dec_cnt_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor read buffer: low byte or high nibble of the result
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            io_data_r <= 8'h00;
        else if (io_sel == IO_SEL_LO)
            io_data_r <= result_r[7:0];
        else
            io_data_r <= {{HI_PAD{1'b0}}, result_r[N_BITS-1:8]};
    end

    assign io_data_o = io_data_r;
    assign io_data_oe = io_rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, read of status clears, set wins
    assign ev = {fire, done_pulse};

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            status_r <= EV_NONE;
        else if (srst)
            status_r <= EV_NONE;
        else if (reg_rd && reg_addr == OFS_STATUS)
            status_r <= ev;
        else
            status_r <= status_r | ev;
    end

    // Interrupt mask
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_r <= EV_NONE;
        else if (reg_wr && reg_addr == OFS_MASK)
            mask_r <= reg_wdata[N_EV-1:0];
    end

    assign irq = |(status_r & mask_r);

    // Register read data, one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFS_STATUS: rdata_r <= {30'h0, status_r};
                OFS_MASK: rdata_r <= {30'h0, mask_r};
                OFS_RESULT: rdata_r <= {20'h0, result_r};
                OFS_STATE: rdata_r <= {26'h0, ready_r, start_n_r, cc_r, state_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
        else
            rdata_r <= 32'h0000_0000;
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    msb_decide_a: assert property ((decide && ptr_r == PTR_MSB && !srst)
        |=> sar_n_r[N_BITS-1] == !$past(comp_in))
        else $error("MSB decision wrong");
    next_bit_a: assert property ((decide && ptr_r != PTR_LSB && !srst)
        |=> ptr_r == ($past(ptr_r) >> 1) && (sar_n_r & ptr_r) == WORD_ZERO)
        else $error("Next bit not tried");
    init_pattern_a: assert property ((tick && !start_n_r && !srst)
        |=> sar_n_r == SAR_INIT && ptr_r == PTR_MSB)
        else $error("First trial pattern wrong");
    trial_hold_a: assert property ((!tick && !srst) |=> $stable(sar_n_r))
        else $error("Register moved between trials");
    conv_length_a: assert property (done_pulse |-> dec_cnt_r == DEC_LAST)
        else $error("Conversion length wrong");
    start_fire_a: assert property ((fire && !srst) |=> !start_n_r && !processor_ready_in)
        else $error("Start not fired");
    shot_width_a: assert property ($fell(start_n_r) |-> !start_n_r[*8])
        else $error("Start pulse too short");
    cc_set_a: assert property ((tick && !start_n_r && !srst) |=> conversion_complete)
        else $error("Complete not set at start");
    ready_release_a: assert property ($rose(start_n_r) |-> processor_ready_in)
        else $error("Ready not released");
    idle_hold_a: assert property ((state_r == ST_IDLE && start_n_r && !srst)
        |=> $stable(sar_n_r) && state_r == ST_IDLE)
        else $error("Idle register changed");
    read_drive_a: assert property (io_rd_hit |-> io_data_oe
        && io_data_o == (($past(io_sel) == IO_SEL_LO) ? $past(result_r[7:0])
        : {{HI_PAD{1'b0}}, $past(result_r[N_BITS-1:8])}))
        else $error("Read buffer not enabled or wrong byte");
    done_flag_a: assert property ((done_pulse && !srst)
        |=> conversion_complete && status_r[EV_DONE] && result_r == ~$past(sar_nxt))
        else $error("Completion not flagged");
    sync_reset_a: assert property (srst
        |=> state_r == ST_IDLE && !conversion_complete && result_r == WORD_ZERO)
        else $error("Reset state wrong");

    conv_done_c: cover property (done_pulse);
    restart_c: cover property (fire ##[1:300] done_pulse);
    irq_c: cover property (irq && reg_rd && reg_addr == OFS_STATUS);
    io_read_c: cover property (io_rd_hit && io_sel != IO_SEL_LO);
endmodule : sac_top
`default_nettype wire

// ---- dv/sac_comp_model.sv ----
// Behavioural comparator watching the converter DAC
`timescale 1ns/10ps
`default_nettype none
module sac_comp_model
(
    input wire logic [11:0] dac_bit_n,
    input wire logic [12:0] level_half,
    input wire logic slow,
    output logic comp_in
);
    logic above;
    // Input in half-LSB steps against the active-high DAC code
    assign above = level_half > {~dac_bit_n, 1'b0};
    // Settles inside one trial, late when slow
    always @(above or slow)
    begin
        comp_in <= #(slow ? 500 : 20) above;
    end
endmodule : sac_comp_model
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench for the acquisition controller
`timescale 1ns/10ps
`default_nettype none
module tb
    import sac_pkg::*;
;
    logic sys_clk, rst_n, srst, cs_n, io_sel, wr_n, rd_n, reg_wr, reg_rd, slow;
    logic io_data_oe, processor_ready_in, comp_in, conversion_complete, irq;
    logic [7:0] io_data_o, reg_addr;
    logic [11:0] dac_bit_n;
    logic [12:0] level_half;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [11:0] vals [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
    logic [7:0] masks [5] = '{8'h01, 8'h02, 8'h00, 8'h03, 8'h01};
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    sac_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .srst(srst), .cs_n(cs_n), .io_sel(io_sel),
        .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .io_data_o(io_data_o),
        .io_data_oe(io_data_oe), .processor_ready_in(processor_ready_in), .comp_in(comp_in),
        .dac_bit_n(dac_bit_n), .conversion_complete(conversion_complete), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    sac_comp_model i_comp (.dac_bit_n(dac_bit_n), .level_half(level_half), .slow(slow), .comp_in(comp_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock and run ceiling
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            stop_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and access tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_read
    task io_start;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        @(posedge sys_clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
    endtask : io_start
    task io_read(input logic sel, input logic [7:0] exp);
        @(posedge sys_clk);
        io_sel <= sel;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge sys_clk);
        #1 check(io_data_oe, 1);
        check(io_data_o, exp);
        @(posedge sys_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        #1 check(io_data_oe, 0);
    endtask : io_read
    task wait_cc(input logic lvl, input int lim);
        #1 n = 0;
        while (conversion_complete !== lvl && n < lim)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(conversion_complete, lvl);
    endtask : wait_cc

    ////////////////////////////////////////////////////////////////////////
    // One conversion with result, status, interrupt and byte reads
    task run_conv(input logic [11:0] v, input logic by_io, input logic [7:0] mask);
        logic [11:0] vn;
        vn = ~v;
        level_half <= {v, 1'b1};
        reg_write(OFS_MASK, {24'h0, mask});
        reg_read(OFS_MASK, d);
        check(d, {24'h0, mask});
        if (by_io)
        begin
            io_start;
            #1 n = 0;
            while (processor_ready_in === 1'b0 && n < 40)
            begin
                n++;
                if (n == 13)
                    check({conversion_complete, dac_bit_n}, {1'b1, SAR_INIT});
                if (n == 4)
                begin
                    io_start;
                    n++;
                end
                else
                    @(posedge sys_clk);
                #1;
            end
            check(n, 15);
        end
        else
            reg_write(OFS_CTRL, 32'h1);
        wait_cc(1'b0, 60);
        wait_cc(1'b1, 200);
        check(n, 77);
        check(dac_bit_n, vn);
        check(irq, |mask[1:0]);
        reg_read(OFS_RESULT, d);
        check(d, {20'h0, v});
        reg_read(OFS_STATUS, d);
        check(d, 32'h3);
        check(irq, 0);
        reg_read(OFS_STATE, d);
        check(d, 32'h39);
        io_read(1'b0, v[7:0]);
        io_read(1'b1, {4'h0, v[11:8]});
        repeat (20) @(posedge sys_clk);
        #1 check({conversion_complete, dac_bit_n}, {1'b1, vn});
    endtask : run_conv

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        srst = 1'b0;
        cs_n = 1'b1;
        io_sel = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        slow = 1'b0;
        level_half = 13'h0000;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 check({irq, processor_ready_in, conversion_complete, dac_bit_n}, {3'b010, SAR_IDLE});
        reg_read(OFS_STATE, d);
        check(d, 32'h31);
        reg_read(8'h14, d);
        check(d, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            slow <= i[0];
            run_conv(vals[i], i != 2, masks[i]);
        end
        // Synchronous reset in mid conversion
        reg_write(OFS_CTRL, 32'h1);
        wait_cc(1'b0, 60);
        repeat (10) @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        #1 check({conversion_complete, dac_bit_n}, {1'b0, SAR_IDLE});
        reg_read(OFS_RESULT, d);
        check(d, {20'h0, WORD_ZERO});
        stop_test;
    end
endmodule : tb
`default_nettype wire
